// ==== core/rwct_core.sv ====
// watchdog, countdown timer, flags and interrupt pin of a serial-bus clock
// assumes the serial engine hands over decoded byte accesses on bus_clk
//
// Functional notes
// - resolution field picks 1/16, 1/4, 1, 4 s
// - watchdog period is multiplier times resolution
// - watchdog flag sets when period expires
// - any watchdog write restarts the period
// - watchdog time-out drives interrupt low
// - watchdog write releases pin; zero disables
// - flags read clears watchdog flag, keeps pin
// - power-up clears watchdog register, disabled
// - timer runs only while enable bit set
// - clock select picks 4096, 64, 1, 1/60 Hz
// - count to 1, then reload and flag
// - value write changes reload only
// - flags read clears timer flag, level release
// - level mode: low while flag set
// - pulse mode: low one tick (1/64 s at 1, 1/60 Hz), high rest
// - n of one, fast source: half period
// - zero reload value stops the timer
// - counting continues regardless of flag, mode
// - level output needs flag and irq enable
// - power-down clears enable; resume held count
// - value read returns the live count
`timescale 1ns/1ps
`default_nettype none

module rwct_core import rwct_pkg::*; #(
  parameter int unsigned BASE_CYCLES = BASE_CYC
) (
  // core clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // byte access port on the bus clock
  input wire logic bus_clk,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic bus_ready,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  // supply status pin
  input wire logic pwr_down,
  // interrupt pin
  output logic irq_out_n
);

  // ---------------- bus clock domain ----------------
  rwct_acc_t acc_q; // access held stable during the crossing
  logic req_tgl_q; // toggles once per access
  logic busy_q; // access in flight
  logic ack_s1_q; // ack synchroniser stage 1
  logic ack_s2_q; // ack synchroniser stage 2
  logic ack_seen_q; // last ack handled
  logic ack_tgl_q; // core domain: toggles when access done
  logic [7:0] rd_hold_q; // core domain: read answer
  logic ack_new; // ack arrived

  assign bus_ready = !busy_q;
  assign ack_new = ack_s2_q != ack_seen_q;

  // capture an access and raise the request toggle
  always_ff @(posedge bus_clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= '0;
      req_tgl_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (bus_valid && !busy_q) begin
      acc_q <= '{wr: bus_write, addr: bus_addr, wdata: bus_wdata};
      req_tgl_q <= ~req_tgl_q;
      busy_q <= 1'b1;
    end else if (ack_new) begin
      busy_q <= 1'b0;
    end
  end

  // bring the ack toggle into the bus domain
  always_ff @(posedge bus_clk or negedge nrst) begin
    if (!nrst) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // finish the access; read data is stable once the ack is seen
  always_ff @(posedge bus_clk or negedge nrst) begin
    if (!nrst) begin
      ack_seen_q <= 1'b0;
      bus_rdata <= 8'h00;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= 1'b0;
      if (ack_new) begin
        ack_seen_q <= ack_s2_q;
        bus_rvalid <= !acc_q.wr;
        if (!acc_q.wr) begin
          bus_rdata <= rd_hold_q;
        end
      end
    end
  end

  // ---------------- core clock domain ----------------
  logic req_s1_q; // request synchroniser stage 1
  logic req_s2_q; // request synchroniser stage 2
  logic req_seen_q; // last request handled
  logic pd_s1_q; // power-down synchroniser stage 1
  logic pd_s2_q; // power-down synchroniser stage 2
  logic acc_stb; // one-cycle access strobe
  logic wr_wd, wr_cval, wr_cctl, rd_fl; // decoded accesses

  // synchronise the request toggle and the power pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_seen_q <= 1'b0;
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_seen_q <= req_s2_q;
      pd_s1_q <= pwr_down;
      pd_s2_q <= pd_s1_q;
    end
  end

  assign acc_stb = req_s2_q != req_seen_q;
  assign wr_wd = acc_stb && acc_q.wr && acc_q.addr == ADDR_WDOG;
  assign wr_cval = acc_stb && acc_q.wr && acc_q.addr == ADDR_CVAL;
  assign wr_cctl = acc_stb && acc_q.wr && acc_q.addr == ADDR_CCTL;
  assign rd_fl = acc_stb && !acc_q.wr && acc_q.addr == ADDR_FLAGS;

  // ---------------- time base ----------------
  logic [15:0] pre_q; // core cycles within one base tick
  logic [14:0] div_q; // base tick divider chain
  logic [5:0] min_q; // seconds within a minute
  logic base_tick; // 8192 Hz strobe

  // true when the low sh bits of the divider are all ones
  function automatic logic low_ones(input logic [14:0] d, input int unsigned sh);
    logic [14:0] m;
    m = 15'((32'h1 << sh) - 32'h1);
    return (d & m) == m;
  endfunction : low_ones

  assign base_tick = pre_q == 16'(BASE_CYCLES - 1);

  // prescaler and divider run from reset on
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= 16'h0000;
      div_q <= 15'h0000;
    end else if (base_tick) begin
      pre_q <= 16'h0000;
      div_q <= div_q + 15'h0001;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // minute prescaler on the one second strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      min_q <= 6'h00;
    end else if (base_tick && low_ones(div_q, SH_1HZ)) begin
      min_q <= (min_q == SEC_PER_MIN - 6'h01) ? 6'h00 : min_q + 6'h01;
    end
  end

  // ---------------- watchdog ----------------
  logic [7:0] wd_reg_q; // watchdog register
  logic [4:0] wd_cnt_q; // elapsed resolution steps
  logic wd_run_q; // watchdog armed
  logic wdf_q; // watchdog flag
  logic wd_req_q; // watchdog interrupt request
  logic [4:0] wd_mult; // watchdog_multiplier
  logic wd_step; // one resolution step
  logic wd_expire; // period just elapsed

  assign wd_mult = wd_reg_q[WD_MULT_LSB +: 5];

  // resolution step select
  always_comb begin
    case (wd_reg_q[WD_RES_LSB +: 2])
      2'b00: wd_step = base_tick && low_ones(div_q, SH_16TH);
      2'b01: wd_step = base_tick && low_ones(div_q, SH_QTR);
      2'b10: wd_step = base_tick && low_ones(div_q, SH_1HZ);
      2'b11: wd_step = base_tick && low_ones(div_q, SH_4S);
      default: wd_step = 1'b0;
    endcase
  end

  // expiry after multiplier steps with no write in between
  assign wd_expire = wd_run_q && wd_step && !wr_wd
      && wd_cnt_q == 5'(wd_mult - 5'h01);

  // register, step counter and arming
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wd_reg_q <= WDOG_RST;
      wd_cnt_q <= 5'h00;
      wd_run_q <= 1'b0;
    end else if (wr_wd) begin
      wd_reg_q <= acc_q.wdata;
      wd_cnt_q <= 5'h00;
      wd_run_q <= acc_q.wdata[WD_MULT_LSB +: 5] != 5'h00;
    end else if (wd_run_q && wd_step) begin
      wd_cnt_q <= wd_cnt_q + 5'h01;
      if (wd_expire) begin
        wd_run_q <= 1'b0;
      end
    end
  end

  // watchdog flag: expiry wins over the read clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wdf_q <= 1'b0;
    end else if (wd_expire) begin
      wdf_q <= 1'b1;
    end else if (rd_fl) begin
      wdf_q <= 1'b0;
    end
  end

  // watchdog request: only a watchdog write releases it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wd_req_q <= 1'b0;
    end else if (wd_expire) begin
      wd_req_q <= 1'b1;
    end else if (wr_wd) begin
      wd_req_q <= 1'b0;
    end
  end

  // ---------------- countdown timer ----------------
  logic [7:0] cctl_q; // timer control register
  logic [7:0] cval_q; // reload value
  logic [7:0] cnt_q; // live count
  logic tf_q; // countdown_flag
  logic [7:0] pl_q; // pulse low time left, base ticks
  logic src_tick; // selected timer tick
  logic run; // counting allowed
  logic reload_evt; // reload with flag
  logic [7:0] pl_len; // pulse length for this source
  logic tmr_req; // timer interrupt request
  rwct_src_t src; // countdown_clock_select

  assign src = rwct_src_t'(cctl_q[CC_TD_LSB +: 2]);

  // timer tick select
  always_comb begin
    case (src)
      SRC_4096: src_tick = base_tick && low_ones(div_q, SH_4096);
      SRC_64: src_tick = base_tick && low_ones(div_q, SH_64);
      SRC_1HZ: src_tick = base_tick && low_ones(div_q, SH_1HZ);
      SRC_MIN: src_tick = base_tick && low_ones(div_q, SH_1HZ)
          && min_q == SEC_PER_MIN - 6'h01;
      default: src_tick = 1'b0;
    endcase
  end

  assign run = cctl_q[CC_TE_BIT] && cval_q != 8'h00;
  assign reload_evt = run && src_tick && cnt_q == 8'h01;

  // control register; power-down drops the enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cctl_q <= CCTL_RST;
    end else if (pd_s2_q) begin
      cctl_q[CC_TE_BIT] <= 1'b0;
    end else if (wr_cctl) begin
      cctl_q <= acc_q.wdata & 8'he3;
    end
  end

  // reload value register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cval_q <= CVAL_RST;
    end else if (wr_cval) begin
      cval_q <= acc_q.wdata;
    end
  end

  // live count; held, not cleared, while disabled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
    end else if (run && src_tick) begin
      if (cnt_q <= 8'h01) begin
        cnt_q <= cval_q;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // timer flag: reload wins over the read clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tf_q <= 1'b0;
    end else if (reload_evt) begin
      tf_q <= 1'b1;
    end else if (rd_fl) begin
      tf_q <= 1'b0;
    end
  end

  // pulse low time by source and reload value
  always_comb begin
    case (src)
      SRC_4096: pl_len = (cval_q == 8'h01) ? PL_HALF_4096 : PL_FULL_4096;
      SRC_64: pl_len = (cval_q == 8'h01) ? PL_HALF_64 : PL_FULL_64;
      default: pl_len = PL_SLOW;
    endcase
  end

  // pulse timer starts with each reload, runs on base ticks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pl_q <= 8'h00;
    end else if (reload_evt) begin
      pl_q <= pl_len;
    end else if (base_tick && pl_q != 8'h00) begin
      pl_q <= pl_q - 8'h01;
    end
  end

  // pulse mode ignores the flag; level mode needs flag and enable
  assign tmr_req = cctl_q[CC_PS_BIT] ? pl_q != 8'h00
      : tf_q && cctl_q[CC_TIE_BIT];

  // shared active-low interrupt pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !(wd_req_q || tmr_req);
    end
  end

  // ---------------- read answer and ack ----------------
  logic [7:0] rd_mux; // selected read data

  always_comb begin
    rd_mux = 8'h00;
    case (acc_q.addr)
      ADDR_WDOG: rd_mux = wd_reg_q;
      ADDR_FLAGS: begin
        rd_mux[FL_WDF_BIT] = wdf_q;
        rd_mux[FL_TF_BIT] = tf_q;
      end
      ADDR_CVAL: rd_mux = cnt_q;
      ADDR_CCTL: rd_mux = cctl_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // latch the answer and toggle the ack
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_hold_q <= 8'h00;
      ack_tgl_q <= 1'b0;
    end else if (acc_stb) begin
      if (!acc_q.wr) begin
        rd_hold_q <= rd_mux;
      end
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_wd_expire;
    wd_run_q && wd_step && !wr_wd && wd_cnt_q == 5'(wd_mult - 5'h01);
  endsequence
  sequence s_reload;
    cctl_q[CC_TE_BIT] && cval_q != 8'h00 && src_tick && cnt_q == 8'h01;
  endsequence

  property p_wd_flag;
    s_wd_expire |=> wdf_q && wd_req_q ##1 !irq_out_n;
  endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("watchdog expiry missed");

  property p_wd_restart;
    wr_wd |=> wd_cnt_q == 5'h00 && !wd_req_q;
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("watchdog write ignored");

  property p_wd_read_keeps;
    rd_fl && wd_req_q && !wr_wd |=> !wdf_q && wd_req_q;
  endproperty
  a_wd_read_keeps: assert property (p_wd_read_keeps) else $error("flags read wrong");

  property p_te_gate;
    !cctl_q[CC_TE_BIT] |=> $stable(cnt_q);
  endproperty
  a_te_gate: assert property (p_te_gate) else $error("count moved while off");

  property p_reload;
    s_reload |=> cnt_q == $past(cval_q) && tf_q;
  endproperty
  a_reload: assert property (p_reload) else $error("reload or flag missed");

  property p_cval_write;
    // a timer tick in the same cycle moves the count by itself
    wr_cval && !src_tick && !rd_fl |=> $stable(tf_q) && $stable(cnt_q);
  endproperty
  a_cval_write: assert property (p_cval_write) else $error("value write leaked");

  property p_zero_stop;
    cval_q == 8'h00 |=> $stable(cnt_q);
  endproperty
  a_zero_stop: assert property (p_zero_stop) else $error("count moved at zero");

  property p_pulse_low;
    s_reload ##1 cctl_q[CC_PS_BIT] |=> !irq_out_n;
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("pulse not low");

  property p_level_release;
    !cctl_q[CC_PS_BIT] && !cctl_q[CC_TIE_BIT] && !wd_req_q [*2] |=> irq_out_n;
  endproperty
  a_level_release: assert property (p_level_release) else $error("pin held low");

endmodule : rwct_core

`default_nettype wire

// ==== include/rwct_pkg.sv ====
// package of the watchdog and countdown timer block: map, fields, timing
// assumes a core clock of 250 MHz and a decoded byte access port
package rwct_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_WDOG = 8'h09;
  localparam logic [7:0] ADDR_FLAGS = 8'h0f;
  localparam logic [7:0] ADDR_CVAL = 8'h10;
  localparam logic [7:0] ADDR_CCTL = 8'h11;

  // field positions
  localparam int WD_MULT_LSB = 2;
  localparam int WD_RES_LSB = 0;
  localparam int FL_WDF_BIT = 7;
  localparam int FL_TF_BIT = 3;
  localparam int CC_TE_BIT = 7;
  localparam int CC_PS_BIT = 6;
  localparam int CC_TIE_BIT = 5;
  localparam int CC_TD_LSB = 0;

  // reset values
  localparam logic [7:0] WDOG_RST = 8'h00;
  localparam logic [7:0] CCTL_RST = 8'h00;
  localparam logic [7:0] CVAL_RST = 8'h00;

  // timing: base tick is 8192 Hz, twice the fastest timer source
  localparam int unsigned REF_HZ = 250_000_000;
  localparam int unsigned BASE_HZ = 8192;
  localparam int unsigned BASE_CYC = REF_HZ / BASE_HZ;
  // base ticks per step, as a power of two
  localparam int unsigned SH_4096 = 1;
  localparam int unsigned SH_64 = 7;
  localparam int unsigned SH_1HZ = 13;
  localparam int unsigned SH_16TH = 9;
  localparam int unsigned SH_QTR = 11;
  localparam int unsigned SH_4S = 15;
  localparam logic [5:0] SEC_PER_MIN = 6'h3c;
  // pulse low times in base ticks
  localparam logic [7:0] PL_FULL_4096 = 8'h02;
  localparam logic [7:0] PL_HALF_4096 = 8'h01;
  localparam logic [7:0] PL_FULL_64 = 8'h80;
  localparam logic [7:0] PL_HALF_64 = 8'h40;
  localparam logic [7:0] PL_SLOW = 8'h80;

  // timer source selection
  typedef enum logic [1:0] {SRC_4096, SRC_64, SRC_1HZ, SRC_MIN} rwct_src_t;

  // one register access carried across the clock crossing
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rwct_acc_t;

endpackage : rwct_pkg

// ==== sim/rwct_host.sv ====
// host model: master of the byte access port on the bus clock
// assumes the core answers with bus_ready and a one-cycle bus_rvalid
`timescale 1ns/1ps
`default_nettype none

module rwct_host (
  // answers from the core
  input wire logic bus_clk,
  input wire logic bus_ready,
  input wire logic bus_rvalid,
  input wire logic [7:0] bus_rdata,
  // request lines
  output logic bus_valid,
  output logic bus_write,
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata
);
  // idle lines at time zero
  initial begin
    bus_valid = 1'b0;
    bus_write = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
  end

  // one access: held until taken, released lines show inverted junk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ok);
    int n;
    logic seen;
    n = 0;
    q = 8'h00;
    seen = 1'b0;
    @(posedge bus_clk);
    bus_valid <= 1'b1;
    bus_write <= w;
    bus_addr <= a;
    bus_wdata <= d;
    // ready is read mid-cycle, so it is the value the next rising edge takes
    while (seen !== 1'b1 && n < 50) begin
      @(negedge bus_clk);
      seen = bus_ready;
      @(posedge bus_clk);
      n++;
    end
    bus_valid <= 1'b0;
    bus_write <= ~w;
    bus_addr <= ~a;
    bus_wdata <= ~d;
    // writes end on ready, reads on the data strobe, both read mid-cycle
    seen = 1'b0;
    while (seen !== 1'b1 && n < 50) begin
      @(negedge bus_clk);
      seen = w ? bus_ready : bus_rvalid;
      n++;
    end
    q = bus_rdata;
    ok = (seen === 1'b1);
  endtask : acc
endmodule : rwct_host

`default_nettype wire

// ==== sim/testbench.sv ====
// testbench of the watchdog and countdown timer core
// assumes the core and the host model; short base tick of 4 cycles
`timescale 1ns/1ps
`default_nettype none

module testbench import rwct_pkg::*;;
  logic ref_clk, nrst, bus_clk, bus_valid, bus_write, bus_ready, bus_rvalid;
  logic pwr_down, irq_out_n;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, rd_q, q0;
  int mismatches, checks_done, cyc, t;

  rwct_core #(.BASE_CYCLES(4)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .bus_clk(bus_clk),
    .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_ready(bus_ready), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .pwr_down(pwr_down), .irq_out_n(irq_out_n));
  rwct_host u_host (.bus_clk(bus_clk), .bus_ready(bus_ready), .bus_rvalid(bus_rvalid),
    .bus_rdata(bus_rdata), .bus_valid(bus_valid), .bus_write(bus_write),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata));

  // core clock, 4 ns
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // bus clock, 160 ns, offset phase; host bus clock far above tick rates read
  initial begin
    bus_clk = 1'b0;
    #13;
    forever #80 bus_clk = ~bus_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 98000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    u_host.acc(1'b1, a, d, q, ok);
    chk(ok, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ok;
    u_host.acc(1'b0, a, 8'h00, rd_q, ok);
    chk(ok, 1'b1);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_q, e);
  endtask : rc
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles
  // wait, sampling between edges, until the pin shows lv
  task automatic waitlv(input logic lv, input int mx, output int n);
    n = 0;
    while (irq_out_n !== lv && n < mx) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < mx, 1'b1);
  endtask : waitlv
  // expiry window of a watchdog setting, then flag reads that leave the pin low
  task automatic wdog(input logic [7:0] v, input int lo, input int hi);
    int n;
    wr(ADDR_WDOG, v);
    chk(irq_out_n, 1'b1);
    waitlv(1'b0, hi, n);
    chk(n > lo, 1'b1);
    rc(ADDR_FLAGS, 8'h80);
    rc(ADDR_FLAGS, 8'h00);
    chk(irq_out_n, 1'b0);
  endtask : wdog
  // free-running pulse: low time and period in core cycles
  task automatic meas(input logic [1:0] s, input logic [7:0] n, input int lo, input int per);
    int l, h, mx;
    mx = 4 * per + 600;
    wr(ADDR_CVAL, n);
    wr(ADDR_CCTL, {3'b111, 3'b000, s});
    waitlv(1'b0, mx, l);
    waitlv(1'b1, mx, l);
    waitlv(1'b0, mx, l);
    waitlv(1'b1, mx, l);
    waitlv(1'b0, mx, h);
    chk(l, lo);
    chk(l + h, per);
  endtask : meas
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    // start high so every flop sees a clean falling reset edge
    nrst = 1'b1;
    pwr_down = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cyc = 0;
    cycles(1);
    nrst <= 1'b0;
    cycles(8);
    nrst <= 1'b1;
    cycles(4);
    @(negedge ref_clk);
    chk(irq_out_n, 1'b1);
    rc(ADDR_WDOG, 8'h00);
    rc(ADDR_CCTL, 8'h00);
    rc(ADDR_FLAGS, 8'h00);
    rc(8'h20, 8'h00);
    $display("test reset done");
    // regular kicks keep the watchdog quiet
    repeat (4) begin
      wr(ADDR_WDOG, 8'h08);
      cycles(1500);
      @(negedge ref_clk);
      chk(irq_out_n, 1'b1);
    end
    wdog(8'h08, 1748, 4200);
    wdog(8'h09, 7892, 16500);
    wr(ADDR_WDOG, 8'h00);
    chk(irq_out_n, 1'b1);
    cycles(5000);
    @(negedge ref_clk);
    chk(irq_out_n, 1'b1);
    $display("test watchdog done");
    // level mode at 64 Hz
    wr(ADDR_CVAL, 8'h03);
    wr(ADDR_CCTL, 8'ha1);
    waitlv(1'b0, 2500, t);
    rc(ADDR_FLAGS, 8'h08);
    chk(irq_out_n, 1'b1);
    waitlv(1'b0, 1700, t);
    wr(ADDR_CVAL, 8'h05);
    chk(irq_out_n, 1'b0);
    wr(ADDR_CCTL, 8'h81);
    chk(irq_out_n, 1'b1);
    wr(ADDR_CCTL, 8'ha1);
    chk(irq_out_n, 1'b0);
    rc(ADDR_CCTL, 8'ha1);
    wr(ADDR_CVAL, 8'h00);
    cycles(3000);
    rd(ADDR_FLAGS);
    cycles(4000);
    rc(ADDR_FLAGS, 8'h00);
    chk(irq_out_n, 1'b1);
    $display("test level done");
    meas(2'b00, 8'h04, 8, 32);
    meas(2'b00, 8'h01, 4, 8);
    meas(2'b01, 8'h05, 512, 2560);
    meas(2'b01, 8'h01, 256, 512);
    meas(2'b01, 8'h02, 512, 1024);
    $display("test pulse done");
    // live count, power-down hold and resume
    wr(ADDR_CVAL, 8'hc8);
    wr(ADDR_CCTL, 8'h81);
    cycles(6000);
    rd(ADDR_CVAL);
    chk(rd_q < 8'hc8 && rd_q > 8'ha0, 1'b1);
    cycles(1);
    pwr_down <= 1'b1;
    cycles(50);
    rc(ADDR_CCTL, 8'h01);
    rd(ADDR_CVAL);
    q0 = rd_q;
    cycles(3000);
    rc(ADDR_CVAL, q0);
    cycles(1);
    pwr_down <= 1'b0;
    wr(ADDR_CCTL, 8'h81);
    cycles(3000);
    rd(ADDR_CVAL);
    chk(rd_q < q0 && rd_q + 8'h0a > q0, 1'b1);
    $display("test power done");
    conclude();
  end
endmodule : testbench

`default_nettype wire
